//--- design/per_event_router.sv
// Peripheral event router top
`timescale 1ns/1ns
`include "per_cfg.svh"
module per_event_router #(
    parameter int NUM_CHANNELS = `PER_NUM_CHANNELS,
    parameter int NUM_GENERATORS = `PER_NUM_GENERATORS,
    parameter int NUM_USERS = `PER_NUM_USERS,
    parameter int NUM_PORTS = `PER_NUM_PORTS
) (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    // Generators
    input wire logic [NUM_GENERATORS-1:0] I_GEN_EVENT,
    input wire logic [NUM_GENERATORS-1:0] I_GEN_IS_ASYNC,
    // Configuration
    input wire per_pkg::per_src_sel_t I_CHANNEL_SOURCE_SELECT [NUM_CHANNELS],
    input wire per_pkg::per_ch_sel_t I_USER_CHANNEL_SELECT [NUM_USERS],
    input wire per_pkg::per_ch_sel_t I_PIN_CHANNEL_SELECT [NUM_PORTS],
    input wire logic [NUM_CHANNELS-1:0] I_SW_EVENT,
    // Channels
    output logic [NUM_CHANNELS-1:0] O_CHAN_ASYNC,
    output logic [NUM_CHANNELS-1:0] O_CHAN_SYNC,
    // Users and pins
    output logic [NUM_USERS-1:0] O_USER_ASYNC,
    output logic [NUM_USERS-1:0] O_USER_SYNC,
    output logic [NUM_PORTS-1:0] O_EVENT_PIN_OUTPUT
);
    import per_pkg::*;

    typedef struct packed {
        logic [NUM_CHANNELS-1:0] sw_pulse;
        logic [NUM_CHANNELS-1:0] sync_direct;
        logic [NUM_CHANNELS-1:0] is_async;
        logic [NUM_USERS-1:0] user_sync;
        logic [NUM_PORTS-1:0] pin;
    } per_state_t;

    per_state_t state;
    per_state_t next_state;
    logic [NUM_CHANNELS-1:0] chan_raw;
    logic [NUM_CHANNELS-1:0] chan_hw;
    logic [NUM_CHANNELS-1:0] chan_async_src;
    logic [NUM_CHANNELS-1:0] chan_synced;
    logic [NUM_CHANNELS-1:0] chan_sync;

    // Per-channel source mux and synchroniser
    genvar gc;
    generate
        for (gc = 0; gc < NUM_CHANNELS; gc++) begin : g_chan
            logic connected;
            logic [$clog2(NUM_GENERATORS)-1:0] idx;
            assign connected = (I_CHANNEL_SOURCE_SELECT[gc] != `PER_SRC_NONE) &&
                               (int'(I_CHANNEL_SOURCE_SELECT[gc]) <= NUM_GENERATORS);
            assign idx = $bits(idx)'(int'(I_CHANNEL_SOURCE_SELECT[gc]) - 1);
            assign chan_hw[gc] = connected & I_GEN_EVENT[idx];
            assign chan_async_src[gc] = connected & I_GEN_IS_ASYNC[idx];
            assign chan_raw[gc] = chan_hw[gc] | state.sw_pulse[gc];
            per_sync u_sync (
                .I_CLOCK(I_CLOCK),
                .I_RST_N(I_RST_N),
                .i_async(chan_hw[gc] & chan_async_src[gc]),
                .o_sync(chan_synced[gc])
            );
            // Async sources go through synchroniser, sync ones bypass it through one register
            assign chan_sync[gc] = state.is_async[gc] ? (chan_synced[gc] | state.sync_direct[gc])
                                                     : state.sync_direct[gc];
        end
    endgenerate

    always_comb begin
        next_state = state;
        next_state.sw_pulse = I_SW_EVENT;
        next_state.is_async = chan_async_src;
        // Sync sources registered once, software events registered a second time
        next_state.sync_direct = (chan_hw & ~chan_async_src) | state.sw_pulse;
        for (int u = 0; u < NUM_USERS; u++) begin
            next_state.user_sync[u] = (I_USER_CHANNEL_SELECT[u] != `PER_USER_NONE) &&
                (int'(I_USER_CHANNEL_SELECT[u]) <= NUM_CHANNELS) &&
                chan_sync[int'(I_USER_CHANNEL_SELECT[u]) - 1];
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            next_state.pin[p] = (I_PIN_CHANNEL_SELECT[p] != `PER_USER_NONE) &&
                (int'(I_PIN_CHANNEL_SELECT[p]) <= NUM_CHANNELS) &&
                chan_sync[int'(I_PIN_CHANNEL_SELECT[p]) - 1];
        end
        if (!I_RST_N) begin
            next_state = '0;
        end
    end

    // Runs on the peripheral clock regardless of CPU sleep
    always_ff @(posedge I_CLOCK) begin
        state <= next_state;
    end

    // Async subchannel and users combinational, no clock needed except for software events, which come from a register
    always_comb begin
        O_USER_ASYNC = '0;
        for (int u = 0; u < NUM_USERS; u++) begin
            if ((I_USER_CHANNEL_SELECT[u] != `PER_USER_NONE) &&
                (int'(I_USER_CHANNEL_SELECT[u]) <= NUM_CHANNELS)) begin
                O_USER_ASYNC[u] = chan_raw[int'(I_USER_CHANNEL_SELECT[u]) - 1];
            end
        end
    end

    assign O_CHAN_ASYNC = chan_raw;
    assign O_CHAN_SYNC = chan_sync;
    assign O_USER_SYNC = state.user_sync;
    assign O_EVENT_PIN_OUTPUT = state.pin;
endmodule // per_event_router

//--- design/per_sync.sv
// Two-flop event synchroniser
`timescale 1ns/1ns
module per_sync (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    // Data
    input wire logic i_async,
    output logic o_sync
);
    typedef struct packed {
        logic meta;
        logic sync;
    } per_sync_state_t;
    per_sync_state_t state;
    per_sync_state_t next_state;
    always_comb begin
        next_state = state;
        next_state.meta = i_async;
        next_state.sync = state.meta;
        if (!I_RST_N) begin
            next_state = '0;
        end
    end
    always_ff @(posedge I_CLOCK) begin
        state <= next_state;
    end
    assign o_sync = state.sync;
endmodule // per_sync

//--- dv/per_event_router_checker.sv
// Checker on the event router ports
`timescale 1ns/1ns
module per_event_router_checker #(parameter int NUM_CHANNELS = 8, parameter int NUM_GENERATORS = 32) (
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic [NUM_GENERATORS-1:0] I_GEN_EVENT,
    input wire logic [NUM_GENERATORS-1:0] I_GEN_IS_ASYNC,
    input wire per_pkg::per_src_sel_t I_CHANNEL_SOURCE_SELECT [NUM_CHANNELS],
    input wire logic [NUM_CHANNELS-1:0] I_SW_EVENT,
    input wire logic [NUM_CHANNELS-1:0] O_CHAN_ASYNC,
    input wire logic [NUM_CHANNELS-1:0] O_CHAN_SYNC
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);
    logic [7:0] s, ps;
    assign s = I_CHANNEL_SOURCE_SELECT[0];
    always_ff @(posedge I_CLOCK) ps <= s;
    wire ok = s == ps && s != 0 && s <= NUM_GENERATORS && !I_SW_EVENT[0];
    wire ge = ok && I_GEN_EVENT[s-8'h01];
    wire ga = ok && I_GEN_IS_ASYNC[s-8'h01];
    sequence s_low; (ga && !ge)[*3]; endsequence
    sequence s_high; (ga && ge)[*3]; endsequence
    a_idle_quiet: assert property ((s == 0 && !I_SW_EVENT[0])[*3] |-> !O_CHAN_SYNC[0] && !O_CHAN_ASYNC[0])
        else $error("idle channel active");
    a_source_mux: assert property (ok && !$past(I_SW_EVENT[0]) |-> O_CHAN_ASYNC[0] == ge)
        else $error("wrong source");
    a_sw_inject: assert property (I_SW_EVENT[0] |=> O_CHAN_ASYNC[0] ##1 O_CHAN_SYNC[0])
        else $error("soft event lost");
    a_sync_follow: assert property ((ok && !ga && ge) ##1 ok |-> O_CHAN_SYNC[0])
        else $error("sync event lost");
    a_sync_pulse: assert property ((ok && !ga && ge) ##1 (ok && !ga && !ge) ##1 ok |-> !O_CHAN_SYNC[0])
        else $error("sync pulse too long");
    a_async_early: assert property (s_low ##1 (ga && ge) ##1 ok |-> !O_CHAN_SYNC[0])
        else $error("async too early");
    a_async_late: assert property (s_low ##1 s_high |-> O_CHAN_SYNC[0])
        else $error("async too late");
    a_async_fall: assert property (s_high ##1 s_low |-> !O_CHAN_SYNC[0])
        else $error("async stuck");
endmodule // per_event_router_checker
bind per_event_router per_event_router_checker #(.NUM_CHANNELS(NUM_CHANNELS), .NUM_GENERATORS(NUM_GENERATORS))
    i_per_event_router_checker (.*);

//--- dv/per_event_router_tb.sv
// Self-checking bench for the event router
`timescale 1ns/1ns
module per_event_router_tb;
    import per_pkg::*;
    logic clk = 0, rst_n = 0;
    logic [31:0] req = '0, ev, isa;
    logic [7:0] sw = '0, ca, cs;
    logic [15:0] ua, us;
    logic [5:0] po;
    per_src_sel_t csel [8] = '{default: 8'h00};
    per_ch_sel_t usel [16] = '{default: 4'h8}, psel [6] = '{default: 4'h8};
    int n_errors = 0, num_checks = 0, c[3], e;
    logic [23:0] rw [7] = '{24'h010001, 24'h010501, 24'h000001, 24'h210001, 24'h111002, 24'h201f03, 24'h030203};
    always #2 clk = ~clk;
    per_gen_model i_per_gen_model (.i_clock(clk), .i_req(req), .o_event(ev), .o_is_async(isa));
    per_event_router i_per_event_router (.I_CLOCK(clk), .I_RST_N(rst_n), .I_GEN_EVENT(ev), .I_GEN_IS_ASYNC(isa),
        .I_CHANNEL_SOURCE_SELECT(csel), .I_USER_CHANNEL_SELECT(usel), .I_PIN_CHANNEL_SELECT(psel), .I_SW_EVENT(sw),
        .O_CHAN_ASYNC(ca), .O_CHAN_SYNC(cs), .O_USER_ASYNC(ua), .O_USER_SYNC(us), .O_EVENT_PIN_OUTPUT(po));
    task chk(input string s, input int x, input int g);
        num_checks++;
        if (x !== g) begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", s, x, g);
        end
    endtask
    task win(input int n, input logic [31:0] r, input logic [7:0] s);
        c = '{default: 0};
        for (int i = 0; i < 12; i++) begin
            @(negedge clk);
            c[0] += (ca === '1 && ua === '1);
            c[1] += (cs === '1);
            c[2] += (us === '1 && po === '1);
            req <= (i >= 3 && i < 3 + n) ? r : '0;
            sw <= (i == 0) ? s : '0;
        end
    endtask
    task final_report;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        chk("reset", 0, {ca, cs, ua, us, po} !== '0);
        rst_n <= 1;
        foreach (rw[k]) begin
            csel = '{default: rw[k][23:16]};
            win(rw[k][7:0], 32'h1 << rw[k][15:8], 8'h00);
            e = (rw[k][23:16] == rw[k][15:8] + 1) ? rw[k][7:0] : 0;
            chk("counts", e * 'h111, c[0] * 'h100 + c[1] * 'h10 + c[2]);
        end
        csel = '{default: 8'h00};
        win(1, '0, 8'hff);
        chk("soft", 'h111, c[0] * 'h100 + c[1] * 'h10 + c[2]);
        csel = '{default: 8'h01};
        usel = '{default: 4'h1};
        psel = '{default: 4'h9};
        rst_n <= 0;
        req <= 32'h1;
        repeat (3) @(negedge clk);
        chk("mid reset", 0, {cs, us, po} !== '0);
        req <= '0;
        @(negedge clk);
        rst_n <= 1;
        win(1, 32'h1, 8'h00);
        chk("after reset", 'h110, c[0] * 'h100 + c[1] * 'h10 + c[2]);
        final_report;
    end
    initial begin
        #(4 * 1000);
        n_errors++;
        final_report;
    end
endmodule // per_event_router_tb

//--- dv/per_gen_model.sv
// Model of the event generating peripherals
`timescale 1ns/1ns
module per_gen_model (
    input wire logic i_clock,
    input wire logic [31:0] i_req,
    output logic [31:0] o_event = '0,
    output logic [31:0] o_is_async
);
    assign o_is_async = 32'hffff0000;
    always @(negedge i_clock) o_event[15:0] <= i_req[15:0];
    always @(negedge i_clock) o_event[31:16] <= #1 i_req[31:16]; // Held whole cycles
endmodule // per_gen_model

//--- inc/per_cfg.svh
// Constants for the peripheral event router
`ifndef PER_CFG_SVH
`define PER_CFG_SVH
`define PER_NUM_CHANNELS 8
`define PER_NUM_GENERATORS 32
`define PER_NUM_USERS 16
`define PER_NUM_PORTS 6
`define PER_SRC_SEL_W 8
`define PER_CH_SEL_W 4
`define PER_SRC_NONE 8'h00
`define PER_USER_NONE 4'h0
`define PER_SYNC_STAGES 2
`endif

//--- inc/per_pkg.sv
// Types for the peripheral event router
package per_pkg;
    typedef logic [7:0] per_src_sel_t;
    typedef logic [3:0] per_ch_sel_t;
endpackage
